// ===== include/tmr_timer8_defs.vh
// constants of the 8-bit timer with compare output and clear-on-match counting
// assumes a single 250 MHz clock and an 8-bit register port with 3 address bits
//
// Overview of operation
// - action zero leaves output state unchanged
// - nonzero action drives output state onto pin when its direction bit is set
// - pin override same in every waveform mode
// - output state register separate, forceable beforehand
// - action applies next match; force acts immediately
// - counting depends on waveform mode only
// - normal mode increments, wraps FF to 00
// - normal overflow flag set as count becomes zero
// - hardware only sets overflow; service clears it
// - counter writable anytime in normal mode
// - clear-on-match mode clears after channel A match
// - channel A flag set at each top
// - compare unbuffered; missed match wraps via FF
// - action one toggles output on every match
// - toggle frequency clk over 2N(1+compare)
// - prescale 1, 8, 32, 64, 128, 256, 1024
// - overflow set passing max to 00 too
// - compare flag set one timer clock later
// - force updates output only, no flag, no clear
// - counter write blocks matches next timer clock
// - writing one to a flag clears it
`ifndef TMR_TIMER8_DEFS_VH
`define TMR_TIMER8_DEFS_VH

`define TMR_ADDR_W 3
`define TMR_OFS_COUNT 3'h0
`define TMR_OFS_CMP_A 3'h1
`define TMR_OFS_CMP_B 3'h2
`define TMR_OFS_CTRL_A 3'h3
`define TMR_OFS_CTRL_B 3'h4
`define TMR_OFS_FLAGS 3'h5
`define TMR_OFS_PIN 3'h6

// control A: action A [7:6], action B [5:4], mode low bits [1:0]
`define TMR_ACT_A_HI 7
`define TMR_ACT_A_LO 6
`define TMR_ACT_B_HI 5
`define TMR_ACT_B_LO 4
`define TMR_WGM_LO_HI 1
`define TMR_WGM_LO_LO 0
// control B: force A [7], force B [6], mode bit 2 [3], clock select [2:0]
`define TMR_FORCE_A_BIT 7
`define TMR_FORCE_B_BIT 6
`define TMR_WGM_HI_BIT 3
`define TMR_CS_HI 2
`define TMR_CS_LO 0
// flags: overflow [0], compare A [1], compare B [2]
`define TMR_FLAG_OVF_BIT 0
`define TMR_FLAG_CMPA_BIT 1
`define TMR_FLAG_CMPB_BIT 2
// pin: latch A [0], latch B [1], direction A [2], direction B [3]
`define TMR_PIN_LATCH_A_BIT 0
`define TMR_PIN_LATCH_B_BIT 1
`define TMR_PIN_DIR_A_BIT 2
`define TMR_PIN_DIR_B_BIT 3

`define TMR_WGM_NORMAL 3'h0
`define TMR_WGM_CTC 3'h2
`define TMR_ACT_NONE 2'h0
`define TMR_ACT_TOGGLE 2'h1
`define TMR_ACT_CLEAR 2'h2
`define TMR_ACT_SET 2'h3

`define TMR_CNT_MAX 8'hFF
`define TMR_CNT_BOTTOM 8'h00
`define TMR_RST_BYTE 8'h00
`define TMR_RST_WGM 3'h0
`define TMR_RST_CS 3'h0

`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV32 3'h3
`define TMR_CS_DIV64 3'h4
`define TMR_CS_DIV128 3'h5
`define TMR_CS_DIV256 3'h6
`define TMR_CS_DIV1024 3'h7
`define TMR_PRE_W 10

`endif

// ===== design/tmr_prescaler.v
// timer clock enable from a free-running divider of the system clock
// assumes clock_select is a synchronous register value
`timescale 1ns/100ps
`include "tmr_timer8_defs.vh"
module tmr_prescaler #(
    parameter PRE_W = `TMR_PRE_W
) (
    input wire clk,
    input wire resetn,
    input wire [2:0] clock_select,
    output reg tick
);
    reg [PRE_W-1:0] pre_q;

    // shared free-running divider: switching factor may shorten the first period
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pre_q <= {PRE_W{1'b0}};
        end else begin
            pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
        end
    end

    always @* begin
        case (clock_select)
            `TMR_CS_STOP: tick = 1'b0;
            `TMR_CS_DIV1: tick = 1'b1;
            `TMR_CS_DIV8: tick = &pre_q[2:0];
            `TMR_CS_DIV32: tick = &pre_q[4:0];
            `TMR_CS_DIV64: tick = &pre_q[5:0];
            `TMR_CS_DIV128: tick = &pre_q[6:0];
            `TMR_CS_DIV256: tick = &pre_q[7:0];
            `TMR_CS_DIV1024: tick = &pre_q[9:0];
            default: tick = 1'b0;
        endcase
    end
endmodule

// ===== design/tmr_compare_out.v
// one compare output channel: output-compare state register and pin override
// assumes match and force are one-cycle qualified pulses from the timer core
`timescale 1ns/100ps
`include "tmr_timer8_defs.vh"
module tmr_compare_out (
    input wire clk,
    input wire resetn,
    input wire match,
    input wire force_strobe,
    input wire [1:0] action,
    input wire port_latch,
    input wire pin_dir,
    output reg state,
    output wire pin_o,
    output wire pin_oe
);
    reg state_d;

    // action read at the event itself, so a new setting waits for the next one
    always @* begin
        state_d = state;
        if (match || force_strobe) begin
            case (action)
                `TMR_ACT_NONE: state_d = state;
                `TMR_ACT_TOGGLE: state_d = ~state;
                `TMR_ACT_CLEAR: state_d = 1'b0;
                `TMR_ACT_SET: state_d = 1'b1;
                default: state_d = state;
            endcase
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= 1'b0;
        end else begin
            state <= state_d;
        end
    end

    // override does not look at the waveform mode at all
    assign pin_o = (|action) ? state : port_latch;
    assign pin_oe = pin_dir;
endmodule

// ===== design/tmr_timer8_ctc.v
// 8-bit timer core: normal and clear-on-match counting, two compare channels,
// register port and pin override
// assumes a one-cycle strobe register master and synchronous inputs
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/100ps
`include "tmr_timer8_defs.vh"
module tmr_timer8_ctc (
    input wire clk,
    input wire resetn,
    input wire [`TMR_ADDR_W-1:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata,
    input wire ovf_ack,
    input wire cmp_a_ack,
    input wire cmp_b_ack,
    output wire overflow_flag,
    output wire channel_a_compare_flag,
    output wire channel_b_compare_flag,
    output wire channel_a_output_state,
    output wire channel_b_output_state,
    output wire pin_a_o,
    output wire pin_a_oe,
    output wire pin_b_o,
    output wire pin_b_oe
);
    localparam NCH = 2;

    reg [7:0] counter_value_q;
    reg [7:0] counter_value_d;
    reg [7:0] channel_a_compare_value_q;
    reg [7:0] channel_b_compare_value_q;
    reg [1:0] channel_a_output_action_q;
    reg [1:0] channel_b_output_action_q;
    reg [2:0] waveform_mode_select_q;
    reg [2:0] clock_select_q;
    reg [1:0] port_latch_q;
    reg [1:0] pin_direction_bit_q;
    reg overflow_flag_q;
    reg overflow_flag_d;
    reg cmp_a_flag_q;
    reg cmp_a_flag_d;
    reg cmp_b_flag_q;
    reg cmp_b_flag_d;
    reg block_q;
    reg block_d;
    reg [7:0] rdata_d;

    wire tick;
    wire wr_count;
    wire wr_cmp_a;
    wire wr_cmp_b;
    wire wr_ctrl_a;
    wire wr_ctrl_b;
    wire wr_flags;
    wire wr_pin;
    wire mode_normal;
    wire mode_ctc;
    wire non_pwm;
    wire eq_a;
    wire eq_b;
    wire match_a;
    wire match_b;
    wire ctc_clear;
    wire ovf_set;
    wire ovf_clr;
    wire cmp_a_clr;
    wire cmp_b_clr;
    wire force_a;
    wire force_b;
    wire [NCH-1:0] ch_match;
    wire [NCH-1:0] ch_force;
    wire [2*NCH-1:0] ch_action;
    wire [NCH-1:0] ch_state;
    wire [NCH-1:0] ch_pin_o;
    wire [NCH-1:0] ch_pin_oe;

    // ---------------------------------------------------------------
    // register port decode
    assign wr_count = wr_en && (addr == `TMR_OFS_COUNT);
    assign wr_cmp_a = wr_en && (addr == `TMR_OFS_CMP_A);
    assign wr_cmp_b = wr_en && (addr == `TMR_OFS_CMP_B);
    assign wr_ctrl_a = wr_en && (addr == `TMR_OFS_CTRL_A);
    assign wr_ctrl_b = wr_en && (addr == `TMR_OFS_CTRL_B);
    assign wr_flags = wr_en && (addr == `TMR_OFS_FLAGS);
    assign wr_pin = wr_en && (addr == `TMR_OFS_PIN);

    // ---------------------------------------------------------------
    // timer clock enable
    tmr_prescaler #(
        .PRE_W(`TMR_PRE_W)
    ) u_prescaler (
        .clk(clk),
        .resetn(resetn),
        .clock_select(clock_select_q),
        .tick(tick)
    );

    // ---------------------------------------------------------------
    // mode decode; only the mode field shapes the count sequence
    assign mode_normal = (waveform_mode_select_q == `TMR_WGM_NORMAL);
    assign mode_ctc = (waveform_mode_select_q == `TMR_WGM_CTC);
    // pwm codes are not built here; they count like normal but refuse force
    assign non_pwm = mode_normal || mode_ctc;

    // ---------------------------------------------------------------
    // comparators run continuously on the live, unbuffered compare values
    assign eq_a = (counter_value_q == channel_a_compare_value_q);
    assign eq_b = (counter_value_q == channel_b_compare_value_q);

    // a match is taken at the timer clock edge ending the equal cycle,
    // unless the cycle follows a counter write
    assign match_a = tick && eq_a && !block_q;
    assign match_b = tick && eq_b && !block_q;

    assign ctc_clear = mode_ctc && match_a;

    // counter write in the same edge as the match wins over its clear; flag and output still take the match
    always @* begin
        counter_value_d = counter_value_q;
        if (wr_count) begin
            counter_value_d = wdata;
        end else if (tick) begin
            if (ctc_clear) begin
                counter_value_d = `TMR_CNT_BOTTOM;
            end else begin
                counter_value_d = counter_value_q + 8'h01;
            end
        end
    end

    // block lasts until the next timer clock edge, even when stopped
    always @* begin
        block_d = block_q;
        if (wr_count) begin
            block_d = 1'b1;
        end else if (tick) begin
            block_d = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // flags: hardware only sets; set wins over any clear in the same cycle
    assign ovf_set = tick && !wr_count && (counter_value_q == `TMR_CNT_MAX);
    assign ovf_clr = (wr_flags && wdata[`TMR_FLAG_OVF_BIT]) || ovf_ack;
    assign cmp_a_clr = (wr_flags && wdata[`TMR_FLAG_CMPA_BIT]) || cmp_a_ack;
    assign cmp_b_clr = (wr_flags && wdata[`TMR_FLAG_CMPB_BIT]) || cmp_b_ack;

    always @* begin
        overflow_flag_d = overflow_flag_q;
        if (ovf_clr) begin
            overflow_flag_d = 1'b0;
        end
        if (ovf_set) begin
            overflow_flag_d = 1'b1;
        end
    end

    always @* begin
        cmp_a_flag_d = cmp_a_flag_q;
        if (cmp_a_clr) begin
            cmp_a_flag_d = 1'b0;
        end
        if (match_a) begin
            cmp_a_flag_d = 1'b1;
        end
    end

    always @* begin
        cmp_b_flag_d = cmp_b_flag_q;
        if (cmp_b_clr) begin
            cmp_b_flag_d = 1'b0;
        end
        if (match_b) begin
            cmp_b_flag_d = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // force strobes are write-only pulses; they touch neither flag nor counter
    assign force_a = wr_ctrl_b && wdata[`TMR_FORCE_A_BIT] && non_pwm;
    assign force_b = wr_ctrl_b && wdata[`TMR_FORCE_B_BIT] && non_pwm;

    // ---------------------------------------------------------------
    // compare output channels
    assign ch_match = {match_b, match_a};
    assign ch_force = {force_b, force_a};
    assign ch_action = {channel_b_output_action_q, channel_a_output_action_q};

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_chan
            tmr_compare_out u_out (
                .clk(clk),
                .resetn(resetn),
                .match(ch_match[gi]),
                .force_strobe(ch_force[gi]),
                .action(ch_action[2*gi+1:2*gi]),
                .port_latch(port_latch_q[gi]),
                .pin_dir(pin_direction_bit_q[gi]),
                .state(ch_state[gi]),
                .pin_o(ch_pin_o[gi]),
                .pin_oe(ch_pin_oe[gi])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // read data: valid only in the cycle after the read strobe
    always @* begin
        rdata_d = `TMR_RST_BYTE;
        if (rd_en) begin
            case (addr)
                `TMR_OFS_COUNT: rdata_d = counter_value_q;
                `TMR_OFS_CMP_A: rdata_d = channel_a_compare_value_q;
                `TMR_OFS_CMP_B: rdata_d = channel_b_compare_value_q;
                `TMR_OFS_CTRL_A: begin
                    rdata_d[`TMR_ACT_A_HI:`TMR_ACT_A_LO] = channel_a_output_action_q;
                    rdata_d[`TMR_ACT_B_HI:`TMR_ACT_B_LO] = channel_b_output_action_q;
                    rdata_d[`TMR_WGM_LO_HI:`TMR_WGM_LO_LO] = waveform_mode_select_q[1:0];
                end
                `TMR_OFS_CTRL_B: begin
                    // force bits always read as zero
                    rdata_d[`TMR_WGM_HI_BIT] = waveform_mode_select_q[2];
                    rdata_d[`TMR_CS_HI:`TMR_CS_LO] = clock_select_q;
                end
                `TMR_OFS_FLAGS: begin
                    rdata_d[`TMR_FLAG_OVF_BIT] = overflow_flag_q;
                    rdata_d[`TMR_FLAG_CMPA_BIT] = cmp_a_flag_q;
                    rdata_d[`TMR_FLAG_CMPB_BIT] = cmp_b_flag_q;
                end
                `TMR_OFS_PIN: begin
                    rdata_d[`TMR_PIN_LATCH_A_BIT] = port_latch_q[0];
                    rdata_d[`TMR_PIN_LATCH_B_BIT] = port_latch_q[1];
                    rdata_d[`TMR_PIN_DIR_A_BIT] = pin_direction_bit_q[0];
                    rdata_d[`TMR_PIN_DIR_B_BIT] = pin_direction_bit_q[1];
                end
                default: rdata_d = `TMR_RST_BYTE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // state registers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            counter_value_q <= `TMR_RST_BYTE;
            block_q <= 1'b0;
            overflow_flag_q <= 1'b0;
            cmp_a_flag_q <= 1'b0;
            cmp_b_flag_q <= 1'b0;
            rdata <= `TMR_RST_BYTE;
        end else begin
            counter_value_q <= counter_value_d;
            block_q <= block_d;
            overflow_flag_q <= overflow_flag_d;
            cmp_a_flag_q <= cmp_a_flag_d;
            cmp_b_flag_q <= cmp_b_flag_d;
            rdata <= rdata_d;
        end
    end

    // software-only configuration registers
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            channel_a_compare_value_q <= `TMR_RST_BYTE;
            channel_b_compare_value_q <= `TMR_RST_BYTE;
            channel_a_output_action_q <= `TMR_ACT_NONE;
            channel_b_output_action_q <= `TMR_ACT_NONE;
            waveform_mode_select_q <= `TMR_RST_WGM;
            clock_select_q <= `TMR_RST_CS;
            port_latch_q <= 2'h0;
            pin_direction_bit_q <= 2'h0;
        end else begin
            // no double buffering: the compare value changes at once
            if (wr_cmp_a) begin
                channel_a_compare_value_q <= wdata;
            end
            if (wr_cmp_b) begin
                channel_b_compare_value_q <= wdata;
            end
            if (wr_ctrl_a) begin
                channel_a_output_action_q <= wdata[`TMR_ACT_A_HI:`TMR_ACT_A_LO];
                channel_b_output_action_q <= wdata[`TMR_ACT_B_HI:`TMR_ACT_B_LO];
                waveform_mode_select_q[1:0] <= wdata[`TMR_WGM_LO_HI:`TMR_WGM_LO_LO];
            end
            if (wr_ctrl_b) begin
                waveform_mode_select_q[2] <= wdata[`TMR_WGM_HI_BIT];
                clock_select_q <= wdata[`TMR_CS_HI:`TMR_CS_LO];
            end
            if (wr_pin) begin
                port_latch_q[0] <= wdata[`TMR_PIN_LATCH_A_BIT];
                port_latch_q[1] <= wdata[`TMR_PIN_LATCH_B_BIT];
                pin_direction_bit_q[0] <= wdata[`TMR_PIN_DIR_A_BIT];
                pin_direction_bit_q[1] <= wdata[`TMR_PIN_DIR_B_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // outputs
    assign overflow_flag = overflow_flag_q;
    assign channel_a_compare_flag = cmp_a_flag_q;
    assign channel_b_compare_flag = cmp_b_flag_q;
    assign channel_a_output_state = ch_state[0];
    assign channel_b_output_state = ch_state[1];
    assign pin_a_o = ch_pin_o[0];
    assign pin_a_oe = ch_pin_oe[0];
    assign pin_b_o = ch_pin_o[1];
    assign pin_b_oe = ch_pin_oe[1];
endmodule

// ===== bench/tmr_pin_pad.sv
// pad of a general-purpose port pin with a weak pull-up
// assumes the timer supplies drive value and drive enable
`timescale 1ns/100ps
module tmr_pin_pad (
    input wire pin_o,
    input wire pin_oe,
    output wire pad
);
    // released pin reads the pull-up level, never its last driven value
    assign pad = pin_oe ? pin_o : 1'b1;
endmodule

// ===== bench/tmr_timer8_ctc_sva.sv
// assertions on the ports of the 8-bit timer
// assumes one clock domain and the register map of the shared defines
`timescale 1ns/100ps
`include "tmr_timer8_defs.vh"
module tmr_timer8_ctc_sva (
    input wire clk,
    input wire resetn,
    input wire [`TMR_ADDR_W-1:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] rdata,
    input wire ovf_ack,
    input wire cmp_a_ack,
    input wire overflow_flag,
    input wire channel_a_compare_flag,
    input wire channel_b_compare_flag,
    input wire channel_a_output_state,
    input wire channel_b_output_state,
    input wire pin_a_o,
    input wire pin_a_oe
);
    reg [1:0] act_q;
    reg [1:0] wgm_lo_q;
    reg wgm_hi_q;
    reg [2:0] cs_q;
    reg latch_q;
    reg dir_q;
    wire clr_ovf;
    wire clr_cmpa;
    // shadow of control bits, so the pin source can be judged from ports
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            act_q <= 2'h0;
            wgm_lo_q <= 2'h0;
            wgm_hi_q <= 1'b0;
            cs_q <= 3'h0;
            latch_q <= 1'b0;
            dir_q <= 1'b0;
        end else if (wr_en) begin
            if (addr == `TMR_OFS_CTRL_A) begin
                act_q <= wdata[7:6];
                wgm_lo_q <= wdata[1:0];
            end
            if (addr == `TMR_OFS_CTRL_B) begin
                wgm_hi_q <= wdata[3];
                cs_q <= wdata[2:0];
            end
            if (addr == `TMR_OFS_PIN) begin
                latch_q <= wdata[0];
                dir_q <= wdata[2];
            end
        end
    end
    assign clr_ovf = ovf_ack || (wr_en && addr == `TMR_OFS_FLAGS && wdata[0]);
    assign clr_cmpa = cmp_a_ack || (wr_en && addr == `TMR_OFS_FLAGS && wdata[1]);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // force while stopped, in mode 0 or 2, so no real match can mix in
    sequence s_force_a;
        wr_en && addr == `TMR_OFS_CTRL_B && wdata[7] && wdata[3:0] == 4'h0
            && cs_q == 3'h0 && !wgm_hi_q && !wgm_lo_q[0];
    endsequence
    AST_PIN_A_SEL: assert property (
        pin_a_o == ((act_q != 2'h0) ? channel_a_output_state : latch_q))
        else $error("pin A value not from selected source");
    AST_PIN_A_OE: assert property (pin_a_oe == dir_q)
        else $error("pin A enable differs from direction bit");
    AST_STATE_HOLD: assert property (
        $changed(channel_a_output_state) |-> $past(act_q) != 2'h0)
        else $error("state A changed with action none");
    AST_FORCE_TOGGLE: assert property (
        s_force_a ##0 act_q == 2'h1 |=> channel_a_output_state != $past(channel_a_output_state))
        else $error("forced toggle did not invert state A");
    AST_FORCE_LEVEL: assert property (
        s_force_a ##0 act_q[1] |=> channel_a_output_state == $past(act_q[0]))
        else $error("forced clear or set gave wrong state A");
    AST_FORCE_NOFLAG: assert property (
        s_force_a ##0 !channel_a_compare_flag |=> !channel_a_compare_flag)
        else $error("force set compare flag A");
    AST_OVF_STICKY: assert property ($fell(overflow_flag) |-> $past(clr_ovf))
        else $error("overflow flag fell without a clear");
    AST_CMPA_STICKY: assert property ($fell(channel_a_compare_flag) |-> $past(clr_cmpa))
        else $error("compare flag A fell without a clear");
    AST_FLAG_READ: assert property (
        rd_en && addr == `TMR_OFS_FLAGS |=> rdata == {5'h00, $past(channel_b_compare_flag),
        $past(channel_a_compare_flag), $past(overflow_flag)})
        else $error("flag read data differs from flags");
    AST_RESET_ZERO: assert property (
        !$past(resetn) |-> !overflow_flag && !channel_a_compare_flag && !channel_b_compare_flag
        && !channel_a_output_state && !channel_b_output_state)
        else $error("flags or states not zero after reset");
endmodule

bind tmr_timer8_ctc tmr_timer8_ctc_sva u_sva (
    .clk, .resetn, .addr, .wdata, .wr_en, .rd_en, .rdata, .ovf_ack, .cmp_a_ack,
    .overflow_flag, .channel_a_compare_flag, .channel_b_compare_flag,
    .channel_a_output_state, .channel_b_output_state, .pin_a_o, .pin_a_oe
);

// ===== bench/tmr_timer8_ctc_tb_top.sv
// self-checking bench for the 8-bit timer with compare output
// assumes a 250 MHz clock and a pull-up pad model on each compare pin
`timescale 1ns/100ps
`include "tmr_timer8_defs.vh"
module tmr_timer8_ctc_tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [2:0] acks = 3'h0;
    wire [7:0] rdata;
    wire [2:0] fl;
    wire st_a, st_b, pa_o, pa_oe, pb_o, pb_oe, pad_a, pad_b;
    int error_cnt = 0;
    int check_count = 0;
    int pre[7] = '{1, 8, 32, 64, 128, 256, 1024};
    int n;
    int g;
    logic s;
    logic [7:0] d;
    logic [7:0] e;

    always #2 clk = ~clk;

    tmr_timer8_ctc uut (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .ovf_ack(acks[0]), .cmp_a_ack(acks[1]),
        .cmp_b_ack(acks[2]), .overflow_flag(fl[0]), .channel_a_compare_flag(fl[1]),
        .channel_b_compare_flag(fl[2]), .channel_a_output_state(st_a),
        .channel_b_output_state(st_b), .pin_a_o(pa_o), .pin_a_oe(pa_oe),
        .pin_b_o(pb_o), .pin_b_oe(pb_oe)
    );
    tmr_pin_pad pad_a_i (.pin_o(pa_o), .pin_oe(pa_oe), .pad(pad_a));
    tmr_pin_pad pad_b_i (.pin_o(pb_o), .pin_oe(pb_oe), .pad(pad_b));

    task automatic chk(input string w, input logic [7:0] x, input logic [7:0] y);
        check_count++;
        if (y !== x) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", w, x, y);
        end
    endtask
    task automatic chkn(input string w, input int x, input int y);
        check_count++;
        if (y != x) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d seen %0d", w, x, y);
        end
    endtask
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // strobes drop for a cycle between transfers, so no double assignment
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        v = rdata;
        @(posedge clk);
    endtask
    task automatic rdc(input string w, input logic [2:0] a, input logic [7:0] x);
        logic [7:0] v;
        rd(a, v);
        chk(w, x, v);
    endtask
    task automatic ack(input logic [2:0] m);
        acks <= m;
        @(posedge clk);
        acks <= 3'h0;
        @(posedge clk);
    endtask
    task automatic wait_flag(input int b);
        int k;
        k = 0;
        #1;
        while (fl[b] !== 1'b1 && k < 600) begin
            @(posedge clk);
            #1;
            k++;
        end
        // a flag that never comes is a mismatch, not a silent skip
        chkn("flag arrived", 1, fl[b] === 1'b1);
    endtask
    // second pass measures a whole interval between two state changes
    task automatic toggle_gap(output int cyc);
        logic v;
        #1;
        for (int k = 0; k < 2; k++) begin
            v = st_a;
            cyc = 0;
            while (st_a === v && cyc < 4000) begin
                @(posedge clk);
                #1;
                cyc++;
            end
        end
    endtask

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        wr(3'h7, 8'hFF);
        for (n = 0; n < 8; n++) begin
            rdc("register", n[2:0], 8'h00);
        end
        chk("status", 8'h60, {1'b0, pad_b, pad_a, st_b, st_a, fl});
        wr(`TMR_OFS_PIN, 8'h04);
        s = 1'b0;
        for (n = 3; n >= 0; n--) begin
            wr(`TMR_OFS_CTRL_A, {n[1:0], 6'h00});
            chk("held", {7'h00, s}, {7'h00, st_a});
            wr(`TMR_OFS_CTRL_B, 8'h80);
            s = (n == 3) ? 1'b1 : (n == 2) ? 1'b0 : (n == 1) ? ~s : s;
            chk("forced", {6'h00, s, 1'b0}, {6'h00, st_a, fl[1]});
            chk("pad", {7'h00, (n == 0) ? 1'b0 : s}, {7'h00, pad_a});
        end
        rdc("count kept", `TMR_OFS_COUNT, 8'h00);
        wr(`TMR_OFS_PIN, 8'h00);
        chk("released", 8'h01, {7'h00, pad_a});
        wr(`TMR_OFS_CMP_A, 8'h05);
        wr(`TMR_OFS_COUNT, 8'h05);
        wr(`TMR_OFS_FLAGS, 8'h07);
        wr(`TMR_OFS_CTRL_B, 8'h01);
        repeat (4) @(posedge clk);
        chk("blocked", 8'h00, {5'h00, fl});
        wr(`TMR_OFS_COUNT, 8'h20);
        rd(`TMR_OFS_COUNT, d);
        rd(`TMR_OFS_COUNT, e);
        chkn("written", 1, d >= 8'h20 && d <= 8'h23);
        chk("step", d + 8'h02, e);
        wait_flag(0);
        rdc("wrap", `TMR_OFS_COUNT, 8'h00);
        wait_flag(1);
        rdc("past match", `TMR_OFS_COUNT, 8'h06);
        ack(3'h7);
        chk("acked", 8'h00, {5'h00, fl});
        wr(`TMR_OFS_CMP_A, 8'h01);
        wr(`TMR_OFS_CTRL_A, 8'h42);
        for (n = 0; n < 7; n++) begin
            wr(`TMR_OFS_CTRL_B, {5'h00, 3'(n + 1)});
            toggle_gap(g);
            chkn("half period", 2 * pre[n], g);
        end
        wr(`TMR_OFS_CTRL_B, 8'h01);
        wr(`TMR_OFS_FLAGS, 8'h07);
        repeat (300) @(posedge clk);
        // compare B still holds zero, which the 0-1 count passes every period
        chk("ctc flags", 8'h06, {5'h00, fl});
        wr(`TMR_OFS_CTRL_B, 8'h00);
        wr(`TMR_OFS_FLAGS, 8'h06);
        chk("cleared", 8'h00, {5'h00, fl});
        rd(`TMR_OFS_COUNT, d);
        chkn("top", 1, d <= 8'h01);
        wr(`TMR_OFS_CTRL_B, 8'h01);
        repeat (4) @(posedge clk);
        chk("again", 8'h06, {5'h00, fl});
        wr(`TMR_OFS_CTRL_B, 8'h00);
        wr(`TMR_OFS_CMP_A, 8'h40);
        wr(`TMR_OFS_COUNT, 8'h50);
        wr(`TMR_OFS_FLAGS, 8'h07);
        wr(`TMR_OFS_CTRL_B, 8'h01);
        wait_flag(0);
        chk("missed", 8'h01, {5'h00, fl});
        wait_flag(1);
        rdc("top clear", `TMR_OFS_COUNT, 8'h00);
        results();
    end

    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        results();
    end
endmodule
